/* File: common/pmd_cfg.svh */
// constants for the mac-side data pins and strap latch
`ifndef PMD_CFG_SVH
`define PMD_CFG_SVH
`define PMD_NIB_W          4
`define PMD_DIBIT_W        2
`define PMD_STRAP_W        2
`define PMD_STRAP_BIT0_PIN 3
`define PMD_STRAP_BIT1_PIN 2
`define PMD_STRAP_RST      2'h0
`define PMD_NIB_RST        4'h0
`define PMD_DIBIT_RST      2'h0
`define PMD_REF_MII_MHZ    25
`define PMD_REF_RMII_MHZ   50
`define PMD_REF_TOL_PPM    50
`endif

/* File: common/pmd_pkg.sv */
// types for the mac-side data pins block
package pmd_pkg;
  typedef enum logic {
    pmd_rx_idle   = 1'b0,
    pmd_rx_second = 1'b1
  } pmd_rx_e;
endpackage

/* File: hdl/pmd_top.sv */
// mac-side data pins, address straps and management clock sampling
//
// Function
// - The crystal feedback output drives only for mii mode with a crystal.
// - During reset the receive data bit 3 pin is latched as address bit 0.
// - During reset the receive data bit 2 pin is latched as address bit 1.
// - Shared strap pins are inputs during reset and outputs after it.
// - Mii receive nibbles follow the link clock, valid only with data valid.
// - Rmii receive gives two bits per link clock while data valid is high.
// - Mii transmit nibbles are taken only while transmit enable is high.
// - Rmii transmit takes two bits per link clock with transmit enable high.
// - The management clock is an input and data is timed against it.
`timescale 1ns/1ps
`include "pmd_cfg.svh"
module pmd_top (
  input  wire logic                      mclk,
  input  wire logic                      reset_n,
  input  wire logic                      link_clk,
  input  wire logic                      rmii_mode,
  input  wire logic                      crystal_ref,
  input  wire logic [`PMD_NIB_W-1:0]     rx_nib,
  input  wire logic                      rx_nib_valid,
  output logic                           rx_nib_ready,
  output logic [`PMD_NIB_W-1:0]          tx_nib,
  output logic                           tx_nib_valid,
  output logic                           tx_overrun,
  output logic [`PMD_NIB_W-1:0]          rxd_out,
  output logic                           rxd_oe,
  input  wire logic [3:2]                rxd_strap_in,
  output logic                           rx_dv,
  input  wire logic [`PMD_NIB_W-1:0]     txd_pin,
  input  wire logic                      tx_en_pin,
  output logic [`PMD_STRAP_W-1:0]        mgmt_address_strap,
  output logic                           crystal_feedback_out,
  output logic                           crystal_feedback_oe,
  input  wire logic                      mgmt_clk,
  input  wire logic                      mgmt_data_in,
  output logic                           mgmt_data_out,
  output logic                           mgmt_data_oe,
  output logic                           mgmt_bit,
  output logic                           mgmt_bit_valid
);
  // mclk domain
  logic [`PMD_STRAP_W-1:0] strap_s1, strap_s2;
  logic [`PMD_NIB_W-1:0]   rx_hold, next_rx_hold;
  logic                    rx_req, next_rx_req, next_rx_nib_ready;
  logic                    ack_s1, ack_s2;
  logic                    treq_s1, treq_s2, tack, next_tack;
  logic [`PMD_NIB_W-1:0]   next_tx_nib;
  logic                    next_tx_nib_valid;
  logic [`PMD_STRAP_W-1:0] next_strap;
  logic                    next_xtal_oe;
  logic                    mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
  logic                    next_mgmt_bit, next_mgmt_bit_valid;
  // link domain
  logic                    link_rst_s1, link_rst_s2, rmii_s1, link_rmii;
  logic                    req_s1, req_s2, rx_ack, next_rx_ack;
  pmd_pkg::pmd_rx_e        rx_state, next_rx_state;
  logic [`PMD_NIB_W-1:0]   next_rxd_out;
  logic                    next_rx_dv;
  logic [`PMD_NIB_W-1:0]   txd_q, tx_word, next_tx_word;
  logic                    tx_en_q, tx_phase, next_tx_phase;
  logic [`PMD_DIBIT_W-1:0] tx_low, next_tx_low;
  logic                    tx_req, next_tx_req, tack_s1, tack_s2;
  logic                    next_tx_overrun, tx_busy;
  logic [`PMD_NIB_W-1:0]   tx_word_w;
  logic                    tx_word_done;

  // mclk: next values
  always_comb begin
    next_strap = mgmt_address_strap;
    if (!reset_n) begin
      next_strap = strap_s2;
    end
    next_rx_hold = rx_hold;
    next_rx_req  = rx_req;
    if (rx_nib_ready && rx_nib_valid) begin
      next_rx_hold = rx_nib;
      next_rx_req  = !rx_req;
    end
    next_rx_nib_ready = (next_rx_req == rx_req) && (rx_req == ack_s2);
    next_tack         = tack;
    next_tx_nib       = tx_nib;
    next_tx_nib_valid = 1'b0;
    if (treq_s2 != tack) begin
      next_tack         = treq_s2;
      next_tx_nib       = tx_word;
      next_tx_nib_valid = 1'b1;
    end
    next_xtal_oe        = !rmii_mode && crystal_ref;
    next_mgmt_bit       = mgmt_bit;
    next_mgmt_bit_valid = 1'b0;
    if (mdc_s2 && !mdc_s3) begin
      next_mgmt_bit       = mdio_s2;
      next_mgmt_bit_valid = 1'b1;
    end
  end

  // mclk: registers
  always_ff @(posedge mclk) begin
    strap_s1           <= {rxd_strap_in[`PMD_STRAP_BIT1_PIN],
                           rxd_strap_in[`PMD_STRAP_BIT0_PIN]};
    strap_s2           <= strap_s1;
    mgmt_address_strap <= next_strap;
    ack_s1             <= rx_ack;
    ack_s2             <= ack_s1;
    treq_s1            <= tx_req;
    treq_s2            <= treq_s1;
    mdc_s1             <= mgmt_clk;
    mdc_s2             <= mdc_s1;
    mdc_s3             <= mdc_s2;
    mdio_s1            <= mgmt_data_in;
    mdio_s2            <= mdio_s1;
    if (!reset_n) begin
      rx_hold              <= `PMD_NIB_RST;
      rx_req               <= 1'b0;
      rx_nib_ready         <= 1'b0;
      tack                 <= 1'b0;
      tx_nib               <= `PMD_NIB_RST;
      tx_nib_valid         <= 1'b0;
      crystal_feedback_oe  <= 1'b0;
      crystal_feedback_out <= 1'b0;
      mgmt_bit             <= 1'b0;
      mgmt_bit_valid       <= 1'b0;
      mgmt_data_out        <= 1'b0;
      mgmt_data_oe         <= 1'b0;
    end else begin
      rx_hold              <= next_rx_hold;
      rx_req               <= next_rx_req;
      rx_nib_ready         <= next_rx_nib_ready;
      tack                 <= next_tack;
      tx_nib               <= next_tx_nib;
      tx_nib_valid         <= next_tx_nib_valid;
      crystal_feedback_oe  <= next_xtal_oe;
      crystal_feedback_out <= 1'b0;
      mgmt_bit             <= next_mgmt_bit;
      mgmt_bit_valid       <= next_mgmt_bit_valid;
      mgmt_data_out        <= 1'b0;
      mgmt_data_oe         <= 1'b0;
    end
  end

  // link: receive next values
  always_comb begin
    next_rx_state = rx_state;
    next_rx_ack   = rx_ack;
    next_rxd_out  = rxd_out;
    next_rx_dv    = 1'b0;
    unique case (rx_state)
      pmd_pkg::pmd_rx_idle: begin
        if (req_s2 != rx_ack) begin
          next_rx_dv = 1'b1;
          if (link_rmii) begin
            next_rxd_out  = {2'h0, rx_hold[1:0]};
            next_rx_state = pmd_pkg::pmd_rx_second;
          end else begin
            next_rxd_out = rx_hold;
            next_rx_ack  = req_s2;
          end
        end
      end
      pmd_pkg::pmd_rx_second: begin
        next_rx_dv    = 1'b1;
        next_rxd_out  = {2'h0, rx_hold[3:2]};
        next_rx_ack   = req_s2;
        next_rx_state = pmd_pkg::pmd_rx_idle;
      end
    endcase
  end

  // link: transmit next values
  assign tx_busy      = tx_req != tack_s2;
  assign tx_word_w    = link_rmii ? {txd_q[1:0], tx_low} : txd_q;
  assign tx_word_done = tx_en_q && (!link_rmii || tx_phase);
  always_comb begin
    next_tx_phase   = 1'b0;
    next_tx_low     = tx_low;
    next_tx_word    = tx_word;
    next_tx_req     = tx_req;
    next_tx_overrun = 1'b0;
    if (tx_en_q) begin
      next_tx_phase = link_rmii && !tx_phase;
      if (link_rmii && !tx_phase) begin
        next_tx_low = txd_q[1:0];
      end
    end
    if (tx_word_done) begin
      if (tx_busy) begin
        next_tx_overrun = 1'b1;
      end else begin
        next_tx_word = tx_word_w;
        next_tx_req  = !tx_req;
      end
    end
  end

  // link: registers
  always_ff @(posedge link_clk) begin
    link_rst_s1 <= !reset_n;
    link_rst_s2 <= link_rst_s1;
    rmii_s1     <= rmii_mode;
    link_rmii   <= rmii_s1;
    req_s1      <= rx_req;
    req_s2      <= req_s1;
    tack_s1     <= tack;
    tack_s2     <= tack_s1;
    txd_q       <= txd_pin;
    tx_en_q     <= tx_en_pin;
    if (link_rst_s2) begin
      rx_state   <= pmd_pkg::pmd_rx_idle;
      rx_ack     <= 1'b0;
      rxd_out    <= `PMD_NIB_RST;
      rx_dv      <= 1'b0;
      rxd_oe     <= 1'b0;
      tx_phase   <= 1'b0;
      tx_low     <= `PMD_DIBIT_RST;
      tx_word    <= `PMD_NIB_RST;
      tx_req     <= 1'b0;
      tx_overrun <= 1'b0;
    end else begin
      rx_state   <= next_rx_state;
      rx_ack     <= next_rx_ack;
      rxd_out    <= next_rxd_out;
      rx_dv      <= next_rx_dv;
      rxd_oe     <= 1'b1;
      tx_phase   <= next_tx_phase;
      tx_low     <= next_tx_low;
      tx_word    <= next_tx_word;
      tx_req     <= next_tx_req;
      tx_overrun <= next_tx_overrun;
    end
  end

  // checks
  sequence s_mii_take;
    !link_rmii && rx_state == pmd_pkg::pmd_rx_idle && req_s2 != rx_ack;
  endsequence
  sequence s_rmii_take;
    link_rmii && rx_state == pmd_pkg::pmd_rx_idle && req_s2 != rx_ack;
  endsequence
  sequence s_rmii_pair;
    tx_en_q && link_rmii && tx_phase && !tx_busy;
  endsequence
  // strap sync needs two reset cycles before its stages hold pin levels
  sequence s_reset_held;
    !reset_n ##1 !reset_n ##1 !reset_n;
  endsequence

  a_strap_hold: assert property (@(posedge mclk)
    disable iff (!reset_n)
    $past(reset_n) |-> $stable(mgmt_address_strap))
    else $error("strap value changed after reset");
  a_strap_bit0: assert property (@(posedge mclk)
    s_reset_held |=> mgmt_address_strap[0] == $past(strap_s2[0]))
    else $error("address bit 0 not taken from rxd3");
  a_strap_bit1: assert property (@(posedge mclk)
    s_reset_held |=> mgmt_address_strap[1] == $past(strap_s2[1]))
    else $error("address bit 1 not taken from rxd2");
  a_xtal_feedback: assert property (@(posedge mclk)
    disable iff (!reset_n)
    crystal_feedback_oe |-> $past(!rmii_mode && crystal_ref))
    else $error("crystal feedback driven outside mii crystal use");
  a_mdc_sample: assert property (@(posedge mclk)
    disable iff (!reset_n)
    mdc_s2 && !mdc_s3 |=> mgmt_bit_valid && mgmt_bit == $past(mdio_s2))
    else $error("management data not sampled on clock rise");
  a_pin_release: assert property (@(posedge link_clk)
    disable iff (link_rst_s2)
    rxd_oe |-> !$past(link_rst_s2))
    else $error("strap pins driven during reset");
  a_mii_rx_nibble: assert property (@(posedge link_clk)
    disable iff (link_rst_s2)
    s_mii_take |=> rx_dv && rxd_out == $past(rx_hold))
    else $error("mii receive nibble wrong");
  a_rmii_rx_pair: assert property (@(posedge link_clk)
    disable iff (link_rst_s2)
    s_rmii_take |=> rx_dv && rxd_out[1:0] == $past(rx_hold[1:0])
    ##1 rx_dv && rxd_out[1:0] == $past(rx_hold[3:2], 2))
    else $error("rmii receive dibits wrong");
  a_tx_ignore: assert property (@(posedge link_clk)
    disable iff (link_rst_s2)
    !tx_en_q |=> $stable(tx_req) && !tx_phase)
    else $error("transmit data taken without enable");
  a_rmii_tx_pair: assert property (@(posedge link_clk)
    disable iff (link_rst_s2)
    s_rmii_pair |=> tx_word == {$past(txd_q[1:0]), $past(tx_low)})
    else $error("rmii transmit nibble wrong");
endmodule

/* File: tb/pmd_mac_model.sv */
// mac-side partner: transmit driver, receive capture, strap pulls
`timescale 1ns/1ps
module pmd_mac_model (
  input  wire logic       link_clk,
  input  wire logic       rmii_mode,
  input  wire logic [3:0] rxd_out,
  input  wire logic       rxd_oe,
  input  wire logic       rx_dv,
  input  wire logic       tx_overrun,
  input  wire logic [3:2] strap_lvl,
  output logic      [3:2] rxd_strap_in,
  output logic      [3:0] txd_pin,
  output logic            tx_en_pin,
  output logic            mgmt_clk,
  output logic            mgmt_data_in
);
  logic [3:0] rx_q[$];
  logic       busy = 1'b0;
  int         ovr_cnt = 0;
  // board straps win while the device releases the pins
  assign rxd_strap_in = (rxd_oe === 1'b1) ? rxd_out[3:2] : strap_lvl;
  // dropped nibbles seen at the pins
  always @(posedge link_clk) begin
    if (tx_overrun === 1'b1) ovr_cnt++;
  end
  initial begin
    txd_pin = 4'hA;
    tx_en_pin = 1'b0;
    mgmt_clk = 1'b0;
    mgmt_data_in = 1'b1;
  end
  always @(posedge link_clk) begin
    if (rx_dv === 1'b1) begin
      rx_q.push_back(rmii_mode ? {2'h0, rxd_out[1:0]} : rxd_out);
    end
  end
  // txd toggles outside frames so stale data is never mistaken
  always @(posedge link_clk) begin
    if (!tx_en_pin && !busy) txd_pin <= ~txd_pin;
  end
  task automatic send_tx(input logic [3:0] n);
    busy = 1'b1;
    @(posedge link_clk);
    tx_en_pin <= 1'b1;
    txd_pin <= rmii_mode ? {2'h0, n[1:0]} : n;
    if (rmii_mode) begin
      @(posedge link_clk);
      txd_pin <= {2'h0, n[3:2]};
    end
    @(posedge link_clk);
    tx_en_pin <= 1'b0;
    busy = 1'b0;
  endtask
  // back to back frame of four nibbles, each nibble equal to n
  task automatic send_stream(input logic [3:0] n);
    busy = 1'b1;
    @(posedge link_clk);
    tx_en_pin <= 1'b1;
    for (int i = 0; i < (rmii_mode ? 8 : 4); i++) begin
      txd_pin <= rmii_mode ? {2'h0, i[0] ? n[3:2] : n[1:0]} : n;
      @(posedge link_clk);
    end
    tx_en_pin <= 1'b0;
    busy = 1'b0;
  endtask
  task automatic mdc_bit(input logic b);
    mgmt_data_in <= b;
    repeat (14) @(posedge link_clk);
    mgmt_clk <= 1'b1;
    repeat (14) @(posedge link_clk);
    mgmt_clk <= 1'b0;
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the mac-side data pins block
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; \
  if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  logic       mclk = 1'b0;
  logic       link_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       rmii_mode = 1'b0;
  logic       crystal_ref = 1'b0;
  logic [3:0] rx_nib = 4'h0;
  logic       rx_nib_valid = 1'b0;
  logic [3:2] strap_lvl = 2'h1;
  logic       rx_nib_ready, tx_nib_valid, tx_overrun, rxd_oe, rx_dv;
  logic [3:0] tx_nib, rxd_out, txd_pin;
  logic [3:2] rxd_strap_in;
  logic [1:0] mgmt_address_strap;
  logic       tx_en_pin, crystal_feedback_out, crystal_feedback_oe;
  logic       mgmt_clk, mgmt_data_in, mgmt_data_out, mgmt_data_oe;
  logic       mgmt_bit, mgmt_bit_valid;
  int         error_cnt = 0;
  int         samples_checked = 0;
  int         k;
  always #25 mclk = ~mclk;
  always #7.5 link_clk = ~link_clk;
  pmd_top pmd_top_i (.mclk, .reset_n, .link_clk, .rmii_mode, .crystal_ref,
    .rx_nib, .rx_nib_valid, .rx_nib_ready, .tx_nib, .tx_nib_valid,
    .tx_overrun, .rxd_out, .rxd_oe, .rxd_strap_in, .rx_dv, .txd_pin,
    .tx_en_pin, .mgmt_address_strap, .crystal_feedback_out,
    .crystal_feedback_oe, .mgmt_clk, .mgmt_data_in, .mgmt_data_out,
    .mgmt_data_oe, .mgmt_bit, .mgmt_bit_valid);
  pmd_mac_model pmd_mac_model_i (.link_clk, .rmii_mode, .rxd_out, .rxd_oe,
    .rx_dv, .tx_overrun, .strap_lvl, .rxd_strap_in, .txd_pin, .tx_en_pin,
    .mgmt_clk, .mgmt_data_in);
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic give_up(input logic ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic do_reset(input logic [3:2] lvl);
    reset_n <= 1'b0;
    strap_lvl <= lvl;
    repeat (6) @(posedge mclk);
    `CHK(rxd_oe, 1'b0)
    reset_n <= 1'b1;
    repeat (12) @(posedge mclk);
    `CHK(mgmt_address_strap, {lvl[2], lvl[3]})
    `CHK(rxd_oe, 1'b1)
  endtask
  task automatic rx_check(input logic [3:0] n);
    int cnt;
    cnt = rmii_mode ? 2 : 1;
    pmd_mac_model_i.rx_q.delete();
    @(posedge mclk);
    rx_nib <= n;
    rx_nib_valid <= 1'b1;
    k = 0;
    do begin @(negedge mclk); k++; end while (!rx_nib_ready && k < 20);
    give_up(rx_nib_ready);
    @(posedge mclk);
    rx_nib_valid <= 1'b0;
    repeat (20) @(posedge mclk);
    `CHK(pmd_mac_model_i.rx_q.size(), cnt)
    if (rmii_mode) begin
      `CHK(pmd_mac_model_i.rx_q[0], {2'h0, n[1:0]})
      `CHK(pmd_mac_model_i.rx_q[1], {2'h0, n[3:2]})
    end else `CHK(pmd_mac_model_i.rx_q[0], n)
  endtask
  task automatic tx_check(input logic [3:0] n);
    pmd_mac_model_i.ovr_cnt = 0;
    fork
      pmd_mac_model_i.send_tx(n);
      begin
        k = 0;
        do begin @(negedge mclk); k++; end while (!tx_nib_valid && k < 30);
        give_up(tx_nib_valid);
        `CHK(tx_nib, n)
      end
    join
    k = 0;
    repeat (20) begin @(negedge mclk); if (tx_nib_valid !== 1'b0) k++; end
    `CHK(k, 0)
    `CHK(pmd_mac_model_i.ovr_cnt, 0)
  endtask
  task automatic tx_stream(input logic [3:0] n);
    pmd_mac_model_i.ovr_cnt = 0;
    fork
      pmd_mac_model_i.send_stream(n);
      begin
        k = 0;
        do begin @(negedge mclk); k++; end while (!tx_nib_valid && k < 30);
        give_up(tx_nib_valid);
        `CHK(tx_nib, n)
      end
    join
    k = 0;
    repeat (20) begin @(negedge mclk); if (tx_nib_valid !== 1'b0) k++; end
    `CHK(k, 0)
    `CHK(pmd_mac_model_i.ovr_cnt, 3)
  endtask
  task automatic xtal_check();
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      rmii_mode <= i[1];
      crystal_ref <= i[0];
      repeat (8) @(posedge mclk);
      `CHK(crystal_feedback_oe, (i == 1))
      `CHK(crystal_feedback_out, 1'b0)
    end
  endtask
  task automatic mgmt_check(input logic b);
    fork
      pmd_mac_model_i.mdc_bit(b);
      begin
        k = 0;
        do begin @(negedge mclk); k++; end while (!mgmt_bit_valid && k < 20);
        give_up(mgmt_bit_valid);
        `CHK(mgmt_bit, b)
        `CHK(mgmt_data_oe, 1'b0)
        `CHK(mgmt_data_out, 1'b0)
      end
    join
  endtask
  initial begin
    do_reset(2'h1);
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk);
      rmii_mode <= m[0];
      repeat (8) @(posedge mclk);
      rx_check(4'hF);
      rx_check(4'h3);
      tx_check(4'h9);
      tx_check(4'h6);
      tx_stream(4'hC);
    end
    `CHK(mgmt_address_strap, 2'h2)
    mgmt_check(1'b1);
    mgmt_check(1'b0);
    xtal_check();
    do_reset(2'h2);
    end_sim();
  end
endmodule
